// ---- src/tcp_params.svh ----
`ifndef TCP_PARAMS_SVH
`define TCP_PARAMS_SVH

// register indices; byte address is four times the index
`define TCP_IDX_TIMER      8'h01
`define TCP_IDX_CMP        8'h07
`define TCP_IDX_OPT        8'h08
`define TCP_IDX_DIR        8'h09
`define TCP_IDX_CLEAR_WATCHDOG_INSTRUCTION     8'h0a

// timer_and_pin_config field positions
`define TCP_OPT_SRC_BIT    5
`define TCP_OPT_EDGE_BIT   4
`define TCP_OPT_ASSIGN_BIT 3
`define TCP_OPT_RATIO_HI   2
`define TCP_OPT_RATIO_LO   0

// comparator_control field positions
`define TCP_CMP_RESULT_BIT 7
`define TCP_CMP_OUTEN_BIT  6
`define TCP_CMP_CLKSEL_BIT 4

// pin_direction bit of the count pin
`define TCP_DIR_PIN_BIT    2

// reset values
`define TCP_OPT_RESET      8'hff
`define TCP_CMP_CTRL_RESET 7'h7f
`define TCP_DIR_RESET      4'hf
`define TCP_TIMER_RESET    8'h00
`define TCP_PRESCALE_RESET 8'h00

// instruction cycles of increment suppression after a count write
`define TCP_WRITE_INHIBIT  2'h2

// bus responses
`define TCP_RESP_OKAY      2'h0
`define TCP_RESP_SLVERR    2'h2

`endif

// ---- src/tcp_pkg.sv ----
package tcp_pkg;

	// quarter phases of one instruction cycle, one oscillator period each
	typedef enum logic [1:0] {
		TCP_PH_ONE,
		TCP_PH_TWO,
		TCP_PH_THREE,
		TCP_PH_FOUR
	} tcp_phase_t;

	typedef logic [7:0] tcp_byte_t;

endpackage

// ---- src/tcp_timer0.sv ----
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

// What this block does
// (R1) timer mode without prescaler: count register increments once per instruction cycle
// (R2) after any write to the count register, increments are held off two cycles
// (R3) source, comparator clock select and pin enable all set: count external pin edges
// (R4) edge select zero counts rising edges, one counts falling edges
// (R5) source set, comparator clock select clear: count comparator internally
// (R6) source set, pin enable clear: comparator drives count pin, loops back as input
// (R7) prescaler serves timer (assign bit clear) or watchdog (assign bit set), never both
// (R8) prescaler gives ratios 1:2 to 1:256 in powers of two from ratio field
// (R9) prescaler is an 8-bit counter software cannot read or write
// (R10) every reset leaves the prescaler at all zeros
// (R11) with prescaler on timer, any count register write clears the prescaler
// (R12) with prescaler on watchdog, clear-watchdog clears the prescaler too
// (R13) prescaler output is sampled in quarter phases two and four
// (R14) without prescaler, external source high and low at least two oscillator periods
// (R15) with prescaler, external period at least four oscillator periods over prescale
// (R16) external counting through prescaler uses a symmetric divider output
// (R17) increment follows an input edge by three to seven oscillator periods; this block takes one to three, or two to four through the prescaler
// (R18) software moves prescaler to watchdog by the prescribed clear and write sequence
// (R19) software clears watchdog before moving prescaler to timer, even if disabled
// (R20) source select set overrides the count pin direction setting
// (R21) count register is an 8-bit readable and writable value
// (R22) ratio code 000 is 1:2, each code doubles, 111 is 1:256
// (R23) count register wraps from ff to 00 and keeps counting
module tcp_timer0 import tcp_pkg::*; #(
	parameter int AW = 12
) (
	input  wire logic          sys_clk,               // oscillator clock, one quarter phase
	input  wire logic          sys_rst,               // async reset, active high
	input  wire logic [AW-1:0] s_axi_awaddr,          // write address
	input  wire logic          s_axi_awvalid,         // write address valid
	output logic               s_axi_awready,         // write address ready
	input  wire logic [31:0]   s_axi_wdata,           // write data
	input  wire logic [3:0]    s_axi_wstrb,           // write byte enables
	input  wire logic          s_axi_wvalid,          // write data valid
	output logic               s_axi_wready,          // write data ready
	output logic [1:0]         s_axi_bresp,           // write response
	output logic               s_axi_bvalid,          // write response valid
	input  wire logic          s_axi_bready,          // write response ready
	input  wire logic [AW-1:0] s_axi_araddr,          // read address
	input  wire logic          s_axi_arvalid,         // read address valid
	output logic               s_axi_arready,         // read address ready
	output logic [31:0]        s_axi_rdata,           // read data
	output logic [1:0]         s_axi_rresp,           // read response
	output logic               s_axi_rvalid,          // read data valid
	input  wire logic          s_axi_rready,          // read data ready
	input  wire logic          external_count_pin_in, // level seen on the count pin
	output logic               external_count_pin_out,// value driven on the count pin
	output logic               external_count_pin_oe, // high while the pin is driven
	input  wire logic          port_pin_data,         // port latch value for the pin
	input  wire logic          comparator_result_bit, // comparator output, polarity applied
	input  wire logic          wdt_tick_in,           // watchdog oscillator tick pulse
	output logic               wdt_post_tick,         // tick handed to the watchdog counter
	output logic               wdt_clear              // pulse clearing the watchdog counter
);

	// register index from a byte address, low two bits ignored
	function automatic tcp_byte_t reg_index(input logic [AW-1:0] addr);
		return addr[9:2];
	endfunction

	tcp_phase_t phase_reg;
	tcp_phase_t phase_next;
	logic       cycle_end;
	logic       sample_phase;

	logic            aw_full_reg;
	logic            w_full_reg;
	logic [AW-1:0]   aw_addr_reg;
	logic [31:0]     w_data_reg;
	logic [3:0]      w_strb_reg;
	logic            bvalid_reg;
	logic [1:0]      bresp_reg;
	logic            rvalid_reg;
	logic [1:0]      rresp_reg;
	logic [31:0]     rdata_reg;
	logic [31:0]     rdata_next;
	logic [1:0]      rresp_next;
	logic            wr_fire;
	tcp_byte_t       wr_idx;
	logic            wr_lane0;
	logic            wr_mapped;
	logic            timer_wr;
	logic            clear_watchdog_instruction_cmd;

	tcp_byte_t       opt_reg;
	logic [6:0]      cmp_reg;
	logic [3:0]      dir_reg;
	tcp_byte_t       timer_count_reg;
	tcp_byte_t       prescale_reg;
	logic [1:0]      inhibit_reg;

	logic            count_source_select;
	logic            count_edge_select;
	logic            prescaler_assign_bit;
	logic [2:0]      prescale_ratio_field;
	logic            comparator_clock_select;
	logic            compare_output_pin_enable;

	logic            ext_src;
	logic            edge_src;
	logic            edge_prev_reg;
	logic            ext_rise;
	logic            ps_evt;
	logic            ps_clear;
	logic            ps_out;
	logic            ps_out_prev_reg;
	logic            samp_src;
	logic            samp_reg;
	logic            sync_evt_reg;
	logic            direct_mode;
	logic            inc_evt;
	logic            post_reg;
	logic            wdt_clear_reg;
	logic            pin_out_reg;
	logic            pin_oe_reg;

	// quarter phase sequencer; four oscillator periods make one instruction cycle
	always_comb begin
		case (phase_reg)
			TCP_PH_ONE:   phase_next = TCP_PH_TWO;
			TCP_PH_TWO:   phase_next = TCP_PH_THREE;
			TCP_PH_THREE: phase_next = TCP_PH_FOUR;
			default:      phase_next = TCP_PH_ONE;
		endcase
	end

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			phase_reg <= TCP_PH_ONE;
		end else begin
			phase_reg <= phase_next;
		end
	end

	assign cycle_end    = (phase_reg == TCP_PH_FOUR);
	assign sample_phase = (phase_reg == TCP_PH_TWO) || (phase_reg == TCP_PH_FOUR); // see (R13)

	// write channels are taken in either order and held until both are present
	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready  = !w_full_reg;
	assign wr_fire       = aw_full_reg && w_full_reg && !bvalid_reg;
	assign wr_idx        = reg_index(aw_addr_reg);
	assign wr_lane0      = w_strb_reg[0];
	assign wr_mapped     = (wr_idx == `TCP_IDX_TIMER) || (wr_idx == `TCP_IDX_CMP) || (wr_idx == `TCP_IDX_OPT)
	                       || (wr_idx == `TCP_IDX_DIR) || (wr_idx == `TCP_IDX_CLEAR_WATCHDOG_INSTRUCTION);
	assign timer_wr      = wr_fire && wr_lane0 && (wr_idx == `TCP_IDX_TIMER);
	assign clear_watchdog_instruction_cmd    = wr_fire && wr_lane0 && (wr_idx == `TCP_IDX_CLEAR_WATCHDOG_INSTRUCTION);

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg  <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg  <= 32'h0;
			w_strb_reg  <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_reg) begin
				aw_full_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_full_reg <= 1'b0;
			end
			if (s_axi_wvalid && !w_full_reg) begin
				w_full_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// write response; unmapped addresses answer with a slave error
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= `TCP_RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_reg <= 1'b1;
			bresp_reg  <= wr_mapped ? `TCP_RESP_OKAY : `TCP_RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_reg <= 1'b0;
		end
	end

	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp  = bresp_reg;

	// read decode; configuration and direction are write-only and read as zero
	always_comb begin
		rdata_next = 32'h0;
		rresp_next = `TCP_RESP_OKAY;
		if (reg_index(s_axi_araddr) == `TCP_IDX_TIMER) begin
			rdata_next[7:0] = timer_count_reg; // see (R21)
		end else if (reg_index(s_axi_araddr) == `TCP_IDX_CMP) begin
			rdata_next[7:0] = {comparator_result_bit, cmp_reg};
		end else if (reg_index(s_axi_araddr) == `TCP_IDX_OPT) begin
			rdata_next = 32'h0;
		end else if (reg_index(s_axi_araddr) == `TCP_IDX_DIR) begin
			rdata_next = 32'h0;
		end else if (reg_index(s_axi_araddr) == `TCP_IDX_CLEAR_WATCHDOG_INSTRUCTION) begin
			rdata_next = 32'h0;
		end else begin
			rresp_next = `TCP_RESP_SLVERR;
		end
	end

	assign s_axi_arready = !rvalid_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rvalid_reg <= 1'b0;
			rdata_reg  <= 32'h0;
			rresp_reg  <= `TCP_RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_reg) begin
			rvalid_reg <= 1'b1;
			rdata_reg  <= rdata_next;
			rresp_reg  <= rresp_next;
		end else if (s_axi_rready) begin
			rvalid_reg <= 1'b0;
		end
	end

	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata  = rdata_reg;
	assign s_axi_rresp  = rresp_reg;

	// configuration registers; the comparator result bit is live, not stored
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			opt_reg <= `TCP_OPT_RESET;
			cmp_reg <= `TCP_CMP_CTRL_RESET;
			dir_reg <= `TCP_DIR_RESET;
		end else if (wr_fire && wr_lane0) begin
			if (wr_idx == `TCP_IDX_OPT) begin
				opt_reg <= w_data_reg[7:0];
			end else if (wr_idx == `TCP_IDX_CMP) begin
				cmp_reg <= w_data_reg[6:0];
			end else if (wr_idx == `TCP_IDX_DIR) begin
				dir_reg <= w_data_reg[3:0];
			end
		end
	end

	assign count_source_select       = opt_reg[`TCP_OPT_SRC_BIT];
	assign count_edge_select         = opt_reg[`TCP_OPT_EDGE_BIT];
	assign prescaler_assign_bit      = opt_reg[`TCP_OPT_ASSIGN_BIT];
	assign prescale_ratio_field      = opt_reg[`TCP_OPT_RATIO_HI:`TCP_OPT_RATIO_LO];
	assign comparator_clock_select   = cmp_reg[`TCP_CMP_CLKSEL_BIT];
	assign compare_output_pin_enable = cmp_reg[`TCP_CMP_OUTEN_BIT];

	// count source: pin when clock select set, else comparator over the internal path;
	// with pin enable clear the pin carries the comparator back in through its input
	assign ext_src  = comparator_clock_select ? external_count_pin_in : comparator_result_bit; // see (R3) see (R5) see (R6)
	assign edge_src = ext_src ^ count_edge_select; // see (R4)
	assign ext_rise = edge_src && !edge_prev_reg;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			edge_prev_reg <= 1'b1; // a level already present at reset is not an edge
		end else begin
			edge_prev_reg <= edge_src;
		end
	end

	// prescaler input: watchdog ticks, counter edges or instruction cycles
	assign ps_evt   = prescaler_assign_bit ? wdt_tick_in : (count_source_select ? ext_rise : cycle_end); // see (R7)
	assign ps_clear = (timer_wr && !prescaler_assign_bit) || (clear_watchdog_instruction_cmd && prescaler_assign_bit); // see (R11) see (R12)
	assign ps_out   = prescale_reg[prescale_ratio_field]; // see (R8) see (R22) see (R16)

	// divider is clocked from sys_clk rather than rippling, so it stays single domain;
	// its selected bit is still a symmetric square wave of the source
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			prescale_reg <= `TCP_PRESCALE_RESET; // see (R10)
		end else if (ps_clear) begin
			prescale_reg <= `TCP_PRESCALE_RESET; // see (R9)
		end else if (ps_evt) begin
			prescale_reg <= prescale_reg + 8'h01;
		end
	end

	// watchdog side: divided tick when assigned, raw tick otherwise
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			ps_out_prev_reg <= 1'b0;
			post_reg        <= 1'b0;
			wdt_clear_reg   <= 1'b0;
		end else begin
			ps_out_prev_reg <= ps_out;
			post_reg        <= prescaler_assign_bit ? (ps_out && !ps_out_prev_reg) : wdt_tick_in; // see (R7)
			wdt_clear_reg   <= clear_watchdog_instruction_cmd; // see (R12)
		end
	end

	assign wdt_post_tick = post_reg;
	assign wdt_clear     = wdt_clear_reg;

	// synchroniser samples only in phases two and four; narrower pulses can be missed
	assign samp_src    = prescaler_assign_bit ? edge_src : ps_out;
	assign direct_mode = !count_source_select && prescaler_assign_bit;

	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			samp_reg     <= 1'b1; // high so no false count follows reset
			sync_evt_reg <= 1'b0;
		end else if (sample_phase) begin
			samp_reg     <= samp_src; // see (R13) see (R14) see (R15)
			sync_evt_reg <= samp_src && !samp_reg; // see (R17)
		end else begin
			sync_evt_reg <= 1'b0;
		end
	end

	assign inc_evt = direct_mode ? cycle_end : sync_evt_reg; // see (R1)

	// suppression counter counts instruction cycles after a count write
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			inhibit_reg <= 2'h0;
		end else if (timer_wr) begin
			inhibit_reg <= `TCP_WRITE_INHIBIT; // see (R2)
		end else if (cycle_end && (inhibit_reg != 2'h0)) begin
			inhibit_reg <= inhibit_reg - 2'h1;
		end
	end

	// count register; byte lane zero carries the value, natural 8-bit wrap
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			timer_count_reg <= `TCP_TIMER_RESET;
		end else if (timer_wr) begin
			timer_count_reg <= w_data_reg[7:0]; // see (R21)
		end else if (inc_evt && (inhibit_reg == 2'h0)) begin
			timer_count_reg <= timer_count_reg + 8'h01; // see (R1) see (R23)
		end
	end

	// count pin: comparator drive when pin enable clear, input when source set,
	// direction register otherwise
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out_reg <= 1'b0;
			pin_oe_reg  <= 1'b0;
		end else if (!compare_output_pin_enable) begin
			pin_out_reg <= comparator_result_bit; // see (R6)
			pin_oe_reg  <= 1'b1;
		end else if (count_source_select) begin
			pin_out_reg <= port_pin_data;
			pin_oe_reg  <= 1'b0; // see (R20)
		end else begin
			pin_out_reg <= port_pin_data;
			pin_oe_reg  <= !dir_reg[`TCP_DIR_PIN_BIT];
		end
	end

	assign external_count_pin_out = pin_out_reg;
	assign external_count_pin_oe  = pin_oe_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	timer_cycle_inc_a: assert property ( // see (R1)
		(direct_mode && cycle_end && inhibit_reg == 2'h0 && !timer_wr)
		|=> timer_count_reg == $past(timer_count_reg) + 8'h01)
		else $error("count did not step once in timer mode");

	write_hold_a: assert property ( // see (R2)
		(inhibit_reg != 2'h0 && !timer_wr) |=> $stable(timer_count_reg))
		else $error("count moved while writes hold it off");

	write_inhibit_load_a: assert property ( // see (R2)
		timer_wr |=> (inhibit_reg == `TCP_WRITE_INHIBIT) ##4 ((inhibit_reg != `TCP_WRITE_INHIBIT) || $past(timer_wr, 4)))
		else $error("suppression not loaded by a count write");

	timer_ps_clear_a: assert property ( // see (R11)
		(timer_wr && !prescaler_assign_bit) |=> prescale_reg == 8'h00)
		else $error("count write left prescaler uncleared");

	wdt_ps_clear_a: assert property ( // see (R12)
		(clear_watchdog_instruction_cmd && prescaler_assign_bit) |=> (prescale_reg == 8'h00 && wdt_clear))
		else $error("watchdog clear left prescaler uncleared");

	pin_loopback_a: assert property ( // see (R6)
		(count_source_select && !compare_output_pin_enable)
		|=> (external_count_pin_oe && external_count_pin_out == $past(comparator_result_bit)))
		else $error("comparator not driven onto count pin");

	pin_override_a: assert property ( // see (R20)
		(count_source_select && compare_output_pin_enable) |=> !external_count_pin_oe)
		else $error("count pin direction not overridden");

	sample_phase_a: assert property ( // see (R13)
		!sample_phase |=> $stable(samp_reg))
		else $error("synchroniser sampled outside phases two and four");

	edge_delay_a: assert property ( // see (R17)
		(ext_rise && count_source_select && prescaler_assign_bit && !samp_reg) ##1 edge_src[*2]
		|-> sync_evt_reg || $past(sync_evt_reg))
		else $error("edge not synchronised within two periods");

endmodule

`default_nettype wire

// ---- verification/test_timer_counter_with_shared_prescaler.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "tcp_params.svh"

module test_timer_counter_with_shared_prescaler import tcp_pkg::*; ;
	localparam logic [11:0] A_TMR = {2'b00, `TCP_IDX_TIMER, 2'b00};
	localparam logic [11:0] A_CMP = {2'b00, `TCP_IDX_CMP, 2'b00};
	localparam logic [11:0] A_OPT = {2'b00, `TCP_IDX_OPT, 2'b00};
	localparam logic [11:0] A_DIR = {2'b00, `TCP_IDX_DIR, 2'b00};
	localparam logic [11:0] A_CLR = {2'b00, `TCP_IDX_CLEAR_WATCHDOG_INSTRUCTION, 2'b00};
	localparam logic [11:0] A_BAD = 12'h030;

	logic        sys_clk, sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        bench_pin, port_pin_data, cmp_bit, wdt_tick_in;
	wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire logic [1:0]  s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic   pin_out, pin_oe, pin_level, wdt_post_tick, wdt_clear;
	int          bad_count, cmp_count, cyc, post_ticks, clears, wr_cyc, rd_cyc, seed;

	// the pin carries the block's drive while enabled, else the outside level
	assign pin_level = pin_oe ? pin_out : bench_pin;

	tcp_timer0 #(.AW(12)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .external_count_pin_in(pin_level), .external_count_pin_out(pin_out),
		.external_count_pin_oe(pin_oe), .port_pin_data(port_pin_data), .comparator_result_bit(cmp_bit),
		.wdt_tick_in(wdt_tick_in), .wdt_post_tick(wdt_post_tick), .wdt_clear(wdt_clear));

	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end

	// edge index plus pulse counters for the watchdog side
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (wdt_post_tick === 1'b1) post_ticks <= post_ticks + 1;
		if (wdt_clear === 1'b1) clears <= clears + 1;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// all bus tasks start and end just after a rising edge
	task automatic wr(input logic [11:0] a, input tcp_byte_t d, output logic [1:0] r);
		logic aw, w;
		int   n;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (aw && s_axi_awready === 1'b1) begin
				aw = 1'b0;
				s_axi_awvalid <= 1'b0;
			end
			if (w && s_axi_wready === 1'b1) begin
				w = 1'b0;
				s_axi_wvalid <= 1'b0;
			end
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		if (n >= 200) bad_count++;
		r = s_axi_bresp;
		wr_cyc = cyc - 1;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ar;
		int   n;
		ar = 1'b1;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (ar && s_axi_arready === 1'b1) begin
				ar = 1'b0;
				rd_cyc = cyc;
				s_axi_arvalid <= 1'b0;
			end
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		if (n >= 200) bad_count++;
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask

	task automatic wait_until(input int t);
		while (cyc < t) @(posedge sys_clk);
	endtask

	task automatic tick(input int k);
		repeat (k) begin
			wdt_tick_in <= 1'b1;
			@(posedge sys_clk);
			wdt_tick_in <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
		repeat (4) @(posedge sys_clk);
	endtask

	// edges of the chosen kind in t toggles from level s
	function automatic int edges(input logic s, input int t, input logic e);
		return t / 2 + (((t % 2) == 1 && s == e) ? 1 : 0);
	endfunction

	task automatic print_verdict;
		$display("tests: %0d compares, %0d mismatches", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// far longer than the whole sequence needs
	initial begin
		#1000000;
		bad_count++;
		print_verdict();
	end

	initial begin
		logic [31:0] d, a0, b0;
		logic [1:0]  r;
		tcp_byte_t   v;
		int          p, tp, tc, m, t1, p0;
		logic        e, sp, sc, ok;
		// response readies stay high, so back-to-back calls never re-assign them
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'h1;
		{bench_pin, port_pin_data, cmp_bit, wdt_tick_in} = 4'h0;
		{bad_count, cmp_count, cyc, post_ticks, clears} = '0;
		seed = 32'hd125a1d5;
		sys_rst = 1'b1;
		repeat (6) @(posedge sys_clk);
		sys_rst <= 1'b0;
		@(posedge sys_clk);
		check(pin_oe, 1'b0);
		rd(A_TMR, d, r);
		check(d, {24'h0, `TCP_TIMER_RESET});
		rd(A_CMP, d, r);
		check(d, {24'h0, 1'b0, `TCP_CMP_CTRL_RESET});
		rd(A_OPT, d, r);
		check(d, 32'h0);
		rd(A_BAD, d, r);
		check(d, 32'h0);
		check(r, `TCP_RESP_SLVERR);
		wr(A_BAD, 8'h00, r);
		check(r, `TCP_RESP_SLVERR);
		$display("test reset values done");
		// timer mode, prescaler on watchdog: one step each instruction cycle
		wr(A_OPT, 8'h08, r);
		check(r, `TCP_RESP_OKAY);
		rd(A_TMR, a0, r);
		t1 = rd_cyc;
		wait_until(t1 + 39);
		rd(A_TMR, b0, r);
		check(8'(b0 - a0), 8'h0a);
		for (int i = 0; i < 4; i++) begin
			v = (i == 0) ? 8'hfe : 8'($random(seed));
			wr(A_TMR, v, r);
			t1 = wr_cyc;
			rd(A_TMR, d, r);
			check(d, {24'h0, v});
			wait_until(t1 + 39);
			rd(A_TMR, d, r);
			ok = (d[7:0] == v + 8'h08) || (d[7:0] == v + 8'h07);
			check(ok, 1'b1);
		end
		$display("test timer mode done");
		// leaving the watchdog: clear it first
		wr(A_CLR, 8'h00, r);
		// every ratio code on the timer: exactly three steps in three periods
		for (int n = 0; n < 8; n++) begin
			wr(A_OPT, {5'b00000, 3'(n)}, r);
			p = 4 << (n + 1);
			repeat (16) @(posedge sys_clk);
			rd(A_TMR, a0, r);
			t1 = rd_cyc;
			wait_until(t1 + 3 * p - 1);
			rd(A_TMR, b0, r);
			check(8'(b0 - a0), 8'h03);
		end
		// a count write restarts 1:256 from zero: bit seven rises 512 edges later
		wr(A_TMR, 8'($random(seed)), r);
		repeat (700) @(posedge sys_clk);
		v = 8'($random(seed));
		wr(A_TMR, v, r);
		t1 = wr_cyc;
		wait_until(t1 + 500);
		rd(A_TMR, d, r);
		check(d, {24'h0, v});
		wait_until(t1 + 600);
		rd(A_TMR, d, r);
		check(d, {24'h0, 8'(v + 8'h01)});
		p0 = post_ticks;
		tick(5);
		check(post_ticks - p0, 5);
		$display("test timer prescaler done");
		// hand-over to the watchdog by the prescribed sequence, target ratio 000
		wr(A_CLR, 8'h00, r);
		wr(A_TMR, 8'h00, r);
		wr(A_OPT, 8'h0f, r);
		wr(A_CLR, 8'h00, r);
		wr(A_OPT, 8'h08, r);
		p0 = clears;
		wr(A_CLR, 8'h00, r);
		repeat (3) @(posedge sys_clk);
		check(clears - p0, 1);
		tick(1);
		p0 = post_ticks;
		wr(A_CLR, 8'h00, r);
		tick(1);
		check(post_ticks - p0, 1);
		tick(8);
		check(post_ticks - p0, 5);
		$display("test watchdog prescaler done");
		// counter sources: pin, comparator inside, comparator looped through the pin
		wr(A_DIR, 8'h00, r);
		for (int i = 0; i < 6; i++) begin
			m = i % 3;
			e = logic'(i / 3);
			wr(A_CMP, {1'b0, m != 2, 1'b1, m != 1, 4'hf}, r);
			wr(A_OPT, {2'b00, 1'b1, e, 1'b1, 3'b111}, r);
			repeat (12) @(posedge sys_clk);
			check({pin_oe, pin_oe & (pin_out ^ cmp_bit)}, {m == 2, 1'b0});
			rd(A_CMP, d, r);
			check(d, {24'h0, cmp_bit, m != 2, 1'b1, m != 1, 4'hf});
			rd(A_TMR, a0, r);
			tp = 1 + ($unsigned($random(seed)) % 12);
			tc = 1 + ($unsigned($random(seed)) % 12);
			sp = pin_level;
			sc = cmp_bit;
			// four edges per level keeps the bare and the divided minimums
			for (int k = 0; k < 12; k++) begin
				if (k < tp) bench_pin <= ~bench_pin;
				if (k < tc) cmp_bit <= ~cmp_bit;
				repeat (4) @(posedge sys_clk);
			end
			repeat (12) @(posedge sys_clk);
			rd(A_TMR, b0, r);
			check(8'(b0 - a0), 8'(m == 0 ? edges(sp, tp, e) : edges(sc, tc, e)));
		end
		$display("test counter modes done");
		// timer mode hands the pin back to its direction bit
		port_pin_data <= 1'($random(seed));
		wr(A_CMP, 8'h7f, r);
		wr(A_OPT, 8'h08, r);
		repeat (3) @(posedge sys_clk);
		check({pin_oe, pin_out}, {1'b1, port_pin_data});
		wr(A_DIR, 8'h0f, r);
		repeat (3) @(posedge sys_clk);
		check(pin_oe, 1'b0);
		$display("test pin direction done");
		print_verdict();
	end
endmodule
`default_nettype wire
